// >>> hdl/tcc_channel.sv
// one capture/compare channel: its value register, edge detector and match detector
`timescale 1ns/1ns
module tcc_channel (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic hold,
	input wire logic is_compare,
	input wire logic [1:0] edge_sel,
	input wire logic [15:0] cnt,
	input wire logic [15:0] cnt_next,
	input wire logic tick,
	input wire logic pin_in,
	input wire logic wr_en,
	input wire logic [15:0] wr_data,
	output logic [15:0] tc_value,
	output logic capture,
	output logic match
);
	import tcc_pkg::*;

	tcc_ch_state_t cur;
	tcc_ch_state_t next_cur;
	logic edge_seen;

	always_comb begin
		next_cur = cur;
		unique case (edge_sel)
			EDGE_RISE: edge_seen = pin_in & ~cur.pin_prev;
			EDGE_FALL: edge_seen = ~pin_in & cur.pin_prev;
			EDGE_ANY: edge_seen = pin_in ^ cur.pin_prev;
			EDGE_OFF: edge_seen = 1'b0;
		endcase
		capture = ~hold & ~is_compare & edge_seen;
		match = ~hold & is_compare & tick & (cnt_next == cur.tc);
		if (!hold) begin
			next_cur.pin_prev = pin_in;
			// capture wins over a bus write landing in the same cycle
			if (capture) begin
				next_cur.tc = cnt;
			end else if (wr_en) begin
				next_cur.tc = wr_data;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	assign tc_value = cur.tc;

endmodule

// >>> hdl/tcc_core.sv
// timer core: free-running counter, eight capture/compare channels, pulse accumulator
// ----------------------------------------------------------------
// Functional notes
// - a 16-bit free-running counter, writable by software, advances on prescaler ticks.
// - eight channels each choose input capture or output compare, plus one pulse accumulator.
// - a capture channel latches the counter on the selected edge of its pin.
// - the 16-bit pulse accumulator counts events or accumulates gated time.
// - in event mode the accumulator takes its input from the channel 7 pin.
// - the channel 7 pin can serve as accumulator input besides capture and compare.
// - in stop mode the whole timer is inactive.
// - in debug freeze the counter runs unless the freeze-stop bit is set.
// - in wait mode the counters run unless the wait-stop bit is set.
// - the counter runs while the timer enable bit is 1 and halts when it is 0.
// - flag-clearing writes act only while timer enable or accumulator enable is set.
// - each register sits at block base plus its offset.
// - reads of the compare-force register return zero.
// - a force bit performs the channel compare pin action at once without setting its flag.
// ----------------------------------------------------------------
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ns
module tcc_core #(
	parameter int CHANNELS = 8
) (
	input wire logic clk,
	input wire logic sys_rst,
	input tcc_pkg::tcc_bus_req_t bus_req,
	output logic [15:0] bus_rdata,
	input wire logic stop_mode,
	input wire logic freeze_mode,
	input wire logic wait_mode,
	input wire logic [CHANNELS-1:0] pin_in,
	output logic [CHANNELS-1:0] pin_out,
	output logic [CHANNELS-1:0] pin_oe,
	output logic irq
);
	import tcc_pkg::*;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic apply_action(input logic [1:0] act, input logic level);
		unique case (act)
			ACT_TOGGLE: apply_action = ~level;
			ACT_CLEAR: apply_action = 1'b0;
			ACT_SET: apply_action = 1'b1;
			ACT_NONE: apply_action = level;
		endcase
	endfunction

	function automatic logic presc_tick(input logic [6:0] presc, input logic [2:0] sel);
		logic [7:0] mask;
		mask = (8'h01 << sel) - 8'h01;
		presc_tick = ((presc & mask[6:0]) == mask[6:0]);
	endfunction

	// ----------------------------------------------------------------
	// state and channel wiring
	// ----------------------------------------------------------------
	tcc_state_t cur;
	tcc_state_t next_cur;
	logic [15:0] tc_val [CHANNELS];
	logic [CHANNELS-1:0] cap_ev;
	logic [CHANNELS-1:0] match_ev;
	logic [CHANNELS-1:0] tc_wr;
	logic [CHANNELS-1:0] force_ev;
	logic [15:0] cnt_next;
	logic tick;
	logic cnt_run;
	logic acc_run;
	logic wr_ok;
	logic clr_ok;
	logic [9:0] set_ev;
	logic [9:0] clr_mask;
	logic acc_step;
	logic acc_pin;
	logic [15:0] rd_word;
	logic [7:0] pins;
	logic ch7_event;

	// counter gating: stop holds it, freeze and wait hold it only with their stop bits set
	assign cnt_run = ~stop_mode & cur.timer_en
		& ~(freeze_mode & cur.freeze_stop)
		& ~(wait_mode & cur.wait_stop);
	assign acc_run = ~stop_mode & cur.acc_en & ~(wait_mode & cur.wait_stop);
	assign tick = cnt_run & presc_tick(cur.presc, cur.presc_sel);
	assign cnt_next = cur.cnt + 16'h0001;
	assign wr_ok = bus_req.wr & ~stop_mode;
	assign acc_pin = pin_in[7];

	generate
		for (genvar i = 0; i < CHANNELS; i++) begin : g_ch
			assign tc_wr[i] = wr_ok && (bus_req.addr == (OFS_TC_FIRST + 6'(2 * i)));
			assign force_ev[i] = wr_ok && (bus_req.addr == OFS_FORCE) && bus_req.wdata[i];
			tcc_channel u_ch (
				.clk(clk),
				.sys_rst(sys_rst),
				.hold(stop_mode),
				.is_compare(cur.func_sel[i]),
				.edge_sel(cur.edge_sel[2*i +: 2]),
				.cnt(cur.cnt),
				.cnt_next(cnt_next),
				.tick(tick),
				.pin_in(pin_in[i]),
				.wr_en(tc_wr[i]),
				.wr_data(bus_req.wdata),
				.tc_value(tc_val[i]),
				.capture(cap_ev[i]),
				.match(match_ev[i])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// read mux
	// ----------------------------------------------------------------
	always_comb begin
		rd_word = 16'h0000;
		unique case (bus_req.addr)
			OFS_FUNC_SEL: rd_word = {8'h00, cur.func_sel};
			OFS_FORCE: rd_word = 16'h0000;
			OFS_CH7_MASK: rd_word = {8'h00, cur.ch7_mask};
			OFS_CH7_DATA: rd_word = {8'h00, cur.ch7_data};
			OFS_CNT_HIGH: rd_word = cur.cnt;
			OFS_CNT_LOW: rd_word = {8'h00, cur.cnt[7:0]};
			OFS_SYS_CTRL: rd_word = {8'h00, cur.timer_en, cur.wait_stop, cur.freeze_stop, 5'h00};
			OFS_OUT_ACTION: rd_word = cur.out_action;
			OFS_EDGE_SEL: rd_word = cur.edge_sel;
			OFS_IRQ_EN: rd_word = {6'h00, cur.irq_en};
			OFS_PRESC: rd_word = {13'h0000, cur.presc_sel};
			OFS_IRQ_STAT: rd_word = {6'h00, cur.irq_stat};
			OFS_ACC_CTRL: rd_word = {9'h000, cur.acc_en, cur.acc_gated, cur.acc_edge, 4'h0};
			OFS_ACC_CNT: rd_word = cur.acc_cnt;
			default: begin
				// offsets are relative to the block base, decoded outside
				if (bus_req.addr >= OFS_TC_FIRST && bus_req.addr <= OFS_TC_LAST && !bus_req.addr[0]) begin
					rd_word = tc_val[bus_req.addr[3:1]];
				end
			end
		endcase
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		next_cur = cur;
		set_ev = 10'h000;
		clr_mask = 10'h000;
		acc_step = 1'b0;
		pins = cur.pin_out;
		ch7_event = 1'b0;
		clr_ok = cur.timer_en | cur.acc_en;
		next_cur.rdata = 16'h0000;
		if (!stop_mode) begin
			// prescaler and free counter
			if (cnt_run) begin
				next_cur.presc = cur.presc + 7'h01;
			end
			if (tick) begin
				next_cur.cnt = cnt_next;
				set_ev[STAT_OVF] = (cur.cnt == CNT_MAX);
			end
			// pulse accumulator: edge counting on the channel 7 pin or gated time
			next_cur.ch7_prev = acc_pin;
			if (acc_run) begin
				if (cur.acc_gated) begin
					if (acc_pin == ~cur.acc_edge) begin
						next_cur.gate_div = cur.gate_div + 6'h01;
						acc_step = (cur.gate_div == GATE_DIV_LAST);
					end
				end else begin
					acc_step = cur.acc_edge ? (acc_pin & ~cur.ch7_prev) : (~acc_pin & cur.ch7_prev);
				end
			end
			if (acc_step) begin
				next_cur.acc_cnt = cur.acc_cnt + 16'h0001;
				set_ev[STAT_ACC_OVF] = (cur.acc_cnt == CNT_MAX);
			end
			// compare and forced pin actions; a force suppresses the flag
			for (int i = 0; i < CHANNELS; i++) begin
				if (cur.func_sel[i] && (match_ev[i] || force_ev[i])) begin
					pins[i] = apply_action(cur.out_action[2*i +: 2], cur.pin_out[i]);
				end
				set_ev[i] = cap_ev[i] | (match_ev[i] & ~force_ev[i]);
			end
			// channel 7 event overrides every masked pin, the channel 7 pin included
			ch7_event = cur.func_sel[7] & (match_ev[7] | force_ev[7]);
			if (ch7_event) begin
				pins = (pins & ~cur.ch7_mask) | (cur.ch7_data & cur.ch7_mask);
			end
			next_cur.pin_out = pins;
			// register writes
			if (wr_ok) begin
				unique case (bus_req.addr)
					OFS_FUNC_SEL: next_cur.func_sel = bus_req.wdata[7:0];
					OFS_CH7_MASK: next_cur.ch7_mask = bus_req.wdata[7:0];
					OFS_CH7_DATA: next_cur.ch7_data = bus_req.wdata[7:0];
					OFS_CNT_HIGH: next_cur.cnt = bus_req.wdata;
					OFS_CNT_LOW: next_cur.cnt = {cur.cnt[15:8], bus_req.wdata[7:0]};
					OFS_SYS_CTRL: begin
						next_cur.timer_en = bus_req.wdata[BIT_TIMER_EN];
						next_cur.wait_stop = bus_req.wdata[BIT_WAIT_STOP];
						next_cur.freeze_stop = bus_req.wdata[BIT_FREEZE_STOP];
					end
					OFS_OUT_ACTION: next_cur.out_action = bus_req.wdata;
					OFS_EDGE_SEL: next_cur.edge_sel = bus_req.wdata;
					OFS_IRQ_EN: next_cur.irq_en = bus_req.wdata[9:0];
					OFS_PRESC: next_cur.presc_sel = bus_req.wdata[2:0];
					OFS_IRQ_CLR: clr_mask = clr_ok ? bus_req.wdata[9:0] : 10'h000;
					OFS_ACC_CTRL: begin
						next_cur.acc_en = bus_req.wdata[BIT_ACC_EN];
						next_cur.acc_gated = bus_req.wdata[BIT_ACC_GATED];
						next_cur.acc_edge = bus_req.wdata[BIT_ACC_EDGE];
					end
					OFS_ACC_CNT: next_cur.acc_cnt = bus_req.wdata;
					default: ;
				endcase
			end
			// sticky flags: a new event wins over a clear in the same cycle
			next_cur.irq_stat = (cur.irq_stat & ~clr_mask) | set_ev;
			if (bus_req.rd) begin
				next_cur.rdata = rd_word;
			end
		end
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign bus_rdata = cur.rdata;
	assign pin_out = cur.pin_out;
	assign irq = |(cur.irq_stat & cur.irq_en);

	generate
		for (genvar i = 0; i < CHANNELS; i++) begin : g_oe
			// channel 7 pin stays an input while the accumulator owns it
			if (i == 7) begin : g_seven
				assign pin_oe[i] = cur.func_sel[i] & ~cur.acc_en
					& ((cur.out_action[2*i +: 2] != ACT_NONE) | cur.ch7_mask[i]);
			end else begin : g_other
				assign pin_oe[i] = cur.func_sel[i] & ((cur.out_action[2*i +: 2] != ACT_NONE) | cur.ch7_mask[i]);
			end
		end
	endgenerate

endmodule

// >>> hdl/tcc_pkg.sv
// package: register map, field positions, reset values and carriers of the timer core
package tcc_pkg;

	// ----------------------------------------------------------------
	// sizes
	// ----------------------------------------------------------------
	localparam int CH_NUM = 8;
	localparam int CNT_W = 16;
	localparam int ADDR_W = 6;
	localparam int DATA_W = 16;
	localparam int PRESC_W = 7;
	localparam int STAT_W = 10;
	localparam int GATE_DIV_W = 6;

	// ----------------------------------------------------------------
	// register offsets from the block base
	// ----------------------------------------------------------------
	localparam logic [5:0] OFS_FUNC_SEL = 6'h00;
	localparam logic [5:0] OFS_FORCE = 6'h01;
	localparam logic [5:0] OFS_CH7_MASK = 6'h02;
	localparam logic [5:0] OFS_CH7_DATA = 6'h03;
	localparam logic [5:0] OFS_CNT_HIGH = 6'h04;
	localparam logic [5:0] OFS_CNT_LOW = 6'h05;
	localparam logic [5:0] OFS_SYS_CTRL = 6'h06;
	localparam logic [5:0] OFS_OUT_ACTION = 6'h08;
	localparam logic [5:0] OFS_EDGE_SEL = 6'h0a;
	localparam logic [5:0] OFS_IRQ_EN = 6'h0c;
	localparam logic [5:0] OFS_PRESC = 6'h0d;
	localparam logic [5:0] OFS_IRQ_STAT = 6'h0e;
	localparam logic [5:0] OFS_TC_FIRST = 6'h10;
	localparam logic [5:0] OFS_TC_LAST = 6'h1f;
	localparam logic [5:0] OFS_ACC_CTRL = 6'h20;
	localparam logic [5:0] OFS_ACC_CNT = 6'h22;
	localparam logic [5:0] OFS_IRQ_CLR = 6'h2c;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int BIT_TIMER_EN = 7;
	localparam int BIT_WAIT_STOP = 6;
	localparam int BIT_FREEZE_STOP = 5;
	localparam int BIT_ACC_EN = 6;
	localparam int BIT_ACC_GATED = 5;
	localparam int BIT_ACC_EDGE = 4;
	localparam int STAT_OVF = 8;
	localparam int STAT_ACC_OVF = 9;

	// ----------------------------------------------------------------
	// values after reset and counts
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [15:0] RST_CNT = 16'h0000;
	localparam logic [15:0] CNT_MAX = 16'hffff;
	localparam logic [5:0] GATE_DIV_LAST = 6'h3f;

	// ----------------------------------------------------------------
	// encodings
	// ----------------------------------------------------------------
	localparam logic [1:0] ACT_NONE = 2'h0;
	localparam logic [1:0] ACT_TOGGLE = 2'h1;
	localparam logic [1:0] ACT_CLEAR = 2'h2;
	localparam logic [1:0] ACT_SET = 2'h3;
	localparam logic [1:0] EDGE_OFF = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;
	localparam logic [1:0] EDGE_ANY = 2'h3;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [5:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} tcc_bus_req_t;

	typedef struct packed {
		logic [15:0] tc;
		logic pin_prev;
	} tcc_ch_state_t;

	typedef struct packed {
		logic [7:0] func_sel;
		logic [7:0] ch7_mask;
		logic [7:0] ch7_data;
		logic [15:0] cnt;
		logic timer_en;
		logic wait_stop;
		logic freeze_stop;
		logic [15:0] out_action;
		logic [15:0] edge_sel;
		logic [9:0] irq_en;
		logic [9:0] irq_stat;
		logic [2:0] presc_sel;
		logic [6:0] presc;
		logic acc_en;
		logic acc_gated;
		logic acc_edge;
		logic [15:0] acc_cnt;
		logic [5:0] gate_div;
		logic ch7_prev;
		logic [7:0] pin_out;
		logic [15:0] rdata;
	} tcc_state_t;

endpackage

// >>> verification/tcc_pin_model.sv
// partner: the eight channel pins as seen from the board side
`timescale 1ns/1ns
module tcc_pin_model (
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe,
	input wire logic [7:0] ext_level,
	output logic [7:0] pin_in
);
	// a driven pin reads back the core's own level, an undriven one follows the board
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule

// >>> verification/tcc_properties.sv
// checker: concurrent properties on the timer core ports
`timescale 1ns/1ns
module tcc_properties
	import tcc_pkg::*;
#(
	parameter int CHANNELS = 8
) (
	input wire logic clk,
	input wire logic sys_rst,
	input tcc_pkg::tcc_bus_req_t bus_req,
	input wire logic [15:0] bus_rdata,
	input wire logic stop_mode,
	input wire logic [CHANNELS-1:0] pin_out,
	input wire logic [CHANNELS-1:0] pin_oe,
	input wire logic irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);

	// ----------------------------------------------------------------
	// register bus
	// ----------------------------------------------------------------
	a_rdata_idle: assert property (bus_rdata != 16'h0000 |-> $past(bus_req.rd) && !$past(stop_mode))
		else $error("read data outside a read answer");
	a_force_zero: assert property (bus_req.rd && bus_req.addr == OFS_FORCE |=> bus_rdata == 16'h0000)
		else $error("force register read not zero");
	a_unmapped_zero: assert property (bus_req.rd && (bus_req.addr inside {[6'h24:6'h2b]} ||
		bus_req.addr > OFS_IRQ_CLR) |=> bus_rdata == 16'h0000)
		else $error("unmapped read not zero");
	a_odd_tc_zero: assert property (bus_req.rd && bus_req.addr[0] &&
		bus_req.addr inside {[OFS_TC_FIRST:OFS_TC_LAST]} |=> bus_rdata == 16'h0000)
		else $error("odd channel value address read not zero");

	// ----------------------------------------------------------------
	// counter, stop, reset
	// ----------------------------------------------------------------
	// two back-to-back counter reads may differ by one tick at most, wrap included
	a_count_step: assert property ((bus_req.rd && bus_req.addr == OFS_CNT_HIGH && !stop_mode)[*2]
		|=> 16'(bus_rdata - $past(bus_rdata)) <= 16'h0001)
		else $error("counter stepped more than one");
	a_stop_quiet: assert property (stop_mode ##1 stop_mode |-> bus_rdata == 16'h0000)
		else $error("read data during stop");
	a_stop_frozen: assert property (stop_mode |=> $stable(pin_out) && $stable(pin_oe) && $stable(irq))
		else $error("outputs moved during stop");
	a_reset_pins: assert property (disable iff (1'b0) sys_rst |=> pin_oe == '0 && pin_out == '0 && !irq)
		else $error("pins or irq not idle after reset");

	c_count_pair: cover property ((bus_req.rd && bus_req.addr == OFS_CNT_HIGH)[*2]);
	c_irq: cover property (irq);
	c_driven: cover property (pin_oe != '0);
endmodule

// >>> verification/timer_capture_compare_core_bench.sv
// testbench: timer core against a cycle-count model of counter, capture, force and accumulator
`timescale 1ns/1ns
module timer_capture_compare_core_bench;
	import tcc_pkg::*;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic stop_mode = 1'b0, freeze_mode = 1'b0, wait_mode = 1'b0, run;
	logic [7:0] ext = 8'h00, pin_in, pin_out, pin_oe;
	logic irq;
	logic [15:0] bus_rdata, got, prev, w;
	logic [4:0] m;
	logic [5:0] regs [3] = '{OFS_CH7_MASK, OFS_CH7_DATA, OFS_FUNC_SEL};
	logic [5:0] rst_regs [5] = '{OFS_FUNC_SEL, OFS_CH7_MASK, OFS_CNT_HIGH, OFS_SYS_CTRL, OFS_IRQ_STAT};
	tcc_bus_req_t q = '0;
	int n_fail = 0, cmp_count = 0, ch, n;
	time tw, tr, tp, t0;

	initial begin
		forever #25 clk = ~clk;
	end

	tcc_core #(.CHANNELS(8)) dut (.clk(clk), .sys_rst(sys_rst), .bus_req(q), .bus_rdata(bus_rdata),
		.stop_mode(stop_mode), .freeze_mode(freeze_mode), .wait_mode(wait_mode), .pin_in(pin_in),
		.pin_out(pin_out), .pin_oe(pin_oe), .irq(irq));
	tcc_pin_model pins (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext), .pin_in(pin_in));

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wr(input logic [5:0] a, input logic [15:0] d);
		@(posedge clk);
		q.addr <= a;
		q.wdata <= d;
		q.wr <= 1'b1;
		@(posedge clk);
		tw = $time;
		q.wr <= 1'b0;
	endtask

	// n reads back to back at one address; got holds the last, prev the one before
	task automatic rd(input logic [5:0] a, input int n = 1);
		@(posedge clk);
		q.addr <= a;
		q.rd <= 1'b1;
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			tr = $time;
			if (i == n - 1) q.rd <= 1'b0;
			@(negedge clk);
			prev = got;
			got = bus_rdata;
		end
	endtask

	task automatic pulse(input int c);
		@(posedge clk);
		ext[c] <= 1'b1;
		tp = $time;
		@(posedge clk);
		ext[c] <= 1'b0;
	endtask

	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(21726));
		repeat (5) @(posedge clk);
		sys_rst <= 1'b0;
		foreach (rst_regs[i]) begin
			rd(rst_regs[i]);
			chk("reset value", 16'h0000, got);
		end
		foreach (regs[i]) begin
			w = 16'($urandom);
			wr(regs[i], {8'h00, w[7:0]});
			rd(regs[i]);
			chk("byte register", {8'h00, w[7:0]}, got);
			wr(regs[i], 16'h0000);
		end
		wr(OFS_SYS_CTRL, 16'h0080);
		w = 16'hfff0 | 16'($urandom_range(15));
		wr(OFS_CNT_HIGH, w);
		t0 = tw;
		repeat (20) @(posedge clk);
		rd(OFS_CNT_HIGH);
		chk("counter wrap", w + 16'((tr - 50 - t0) / 50), got);
		ch = $urandom_range(6);
		wr(OFS_EDGE_SEL, 16'(1 << (2 * ch)));
		wr(OFS_IRQ_EN, 16'h1 << ch);
		pulse(ch);
		repeat (2) @(posedge clk);
		rd(OFS_TC_FIRST + 6'(2 * ch));
		chk("capture time", w + 16'((tp - t0) / 50), got);
		chk("irq raised", 16'h1, {15'h0, irq});
		// clear is ignored with both enables low, so the flags must survive it
		wr(OFS_SYS_CTRL, 16'h0000);
		wr(OFS_IRQ_CLR, 16'h03ff);
		rd(OFS_IRQ_STAT);
		chk("flags kept", 16'h0100 | (16'h1 << ch), got);
		wr(OFS_SYS_CTRL, 16'h0080);
		wr(OFS_IRQ_CLR, 16'h03ff);
		rd(OFS_IRQ_STAT);
		chk("flags cleared", 16'h0000, got);
		chk("irq dropped", 16'h0000, {15'h0, irq});
		for (int k = 0; k < 32; k++) begin
			m = 5'(k);
			wr(OFS_SYS_CTRL, {8'h00, m[4], m[3], m[2], 5'h00});
			freeze_mode <= m[0];
			wait_mode <= m[1];
			run = m[4] && !(m[3] && m[1]) && !(m[2] && m[0]);
			rd(OFS_CNT_HIGH, 2);
			chk("counter step", {15'h0, run}, got - prev);
		end
		freeze_mode <= 1'b0;
		wait_mode <= 1'b0;
		wr(OFS_SYS_CTRL, 16'h0080);
		// divide by 4: forty clocks between the two sampled edges give exactly ten ticks
		wr(OFS_PRESC, 16'h0002);
		rd(OFS_CNT_HIGH);
		w = got;
		repeat (38) @(posedge clk);
		rd(OFS_CNT_HIGH);
		chk("divided count", 16'h000a, got - w);
		wr(OFS_PRESC, 16'h0000);
		wr(OFS_FUNC_SEL, 16'h1 << ch);
		wr(OFS_OUT_ACTION, 16'(3 << (2 * ch)));
		wr(OFS_FORCE, 16'h1 << ch);
		repeat (2) @(posedge clk);
		chk("forced pin", 16'h1, {15'h0, pin_out[ch]});
		chk("forced enable", 16'h1, {15'h0, pin_oe[ch]});
		rd(OFS_FORCE);
		chk("force readback", 16'h0000, got);
		rd(OFS_IRQ_STAT);
		chk("no forced flag", 16'h0000, got);
		wr(OFS_OUT_ACTION, 16'(1 << (2 * ch)));
		rd(OFS_CNT_HIGH);
		wr(OFS_TC_FIRST + 6'(2 * ch), got + 16'd40);
		repeat (60) @(posedge clk);
		chk("toggled pin", 16'h0, {15'h0, pin_out[ch]});
		rd(OFS_IRQ_STAT);
		chk("match flag", 16'h1 << ch, got);
		// drive the channel 7 pin first, so that handing it to the accumulator must release it
		wr(OFS_CH7_MASK, 16'h0080);
		wr(OFS_FUNC_SEL, 16'h0080 | (16'h1 << ch));
		@(negedge clk);
		chk("ch7 pin driven", 16'h1, {15'h0, pin_oe[7]});
		wr(OFS_ACC_CTRL, 16'h0050);
		n = $urandom_range(1, 9);
		repeat (n) pulse(7);
		repeat (2) @(posedge clk);
		rd(OFS_ACC_CNT);
		chk("event count", 16'(n), got);
		chk("shared pin input", 16'h0, {15'h0, pin_oe[7]});
		// gated time: pin high for 64 clocks per count
		wr(OFS_ACC_CTRL, 16'h0060);
		wr(OFS_ACC_CNT, 16'h0000);
		ext[7] <= 1'b1;
		repeat (64 * n) @(posedge clk);
		ext[7] <= 1'b0;
		rd(OFS_ACC_CNT);
		chk("gated count", 16'(n), got);
		rd(6'h24);
		chk("reserved read", 16'h0000, got);
		rd(6'h11);
		chk("odd value read", 16'h0000, got);
		@(posedge clk);
		stop_mode <= 1'b1;
		wr(OFS_FUNC_SEL, 16'h0000);
		rd(OFS_CNT_HIGH);
		chk("stop read", 16'h0000, got);
		@(posedge clk);
		stop_mode <= 1'b0;
		rd(OFS_FUNC_SEL);
		chk("stop write ignored", 16'h0080 | (16'h1 << ch), got);
		@(posedge clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		rd(OFS_FUNC_SEL);
		chk("capture after reset", 16'h0000, got);
		chk("pins idle", 16'h0000, {8'h00, pin_oe});
		stop_test;
	end

	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		stop_test;
	end
endmodule

bind tcc_core tcc_properties #(.CHANNELS(CHANNELS)) props (.clk(clk), .sys_rst(sys_rst), .bus_req(bus_req),
	.bus_rdata(bus_rdata), .stop_mode(stop_mode), .pin_out(pin_out), .pin_oe(pin_oe), .irq(irq));
